// File: hdl/fesb_defs.svh
// Register map, field positions, reset values and timing counts of the event status bank.
// Assumes inclusion by the bank module only.
`ifndef FESB_DEFS_SVH
`define FESB_DEFS_SVH
`define FESB_OFS_STATUS3 8'h00
`define FESB_OFS_STATUS4 8'h04
`define FESB_OFS_MASK3 8'h08
`define FESB_OFS_MASK4 8'h0c
`define FESB_OFS_CTRL 8'h10
`define FESB_OFS_ES_MASK 8'h14
`define FESB_OFS_GSUM 8'h18
`define FESB_OFS_RX_COUNT 8'h1c
// Status three bits
`define FESB_S3_ES 7
`define FESB_S3_SEC 6
`define FESB_S3_LOOPBACK_STATUS_CHANGE_FLAG 3
`define FESB_S3_RSN 1
`define FESB_S3_RSP 0
// Status four bits
`define FESB_S4_XSP 7
`define FESB_S4_XSN 6
`define FESB_S4_RME 5
`define FESB_S4_RFS 4
`define FESB_S4_RDO 3
`define FESB_S4_ALLS 2
`define FESB_S4_XDU 1
`define FESB_S4_RPF 0
// Control bits
`define FESB_CTRL_VIS 0
`define FESB_CTRL_EPRM 1
`define FESB_CTRL_HDLC 2
// Summary bits
`define FESB_GSUM_S3 3
`define FESB_GSUM_S4 4
// Reset values
`define FESB_RST_MASK 8'h00
`define FESB_RST_CTRL 8'h04
`define FESB_RST_ES_MASK 8'h00
// Timing
`define FESB_CLK_MHZ 100
`define FESB_RX_CLK_HZ 1544000
`define FESB_LLB_TIME_US 33160
`define FESB_LLB_CYCLES (`FESB_LLB_TIME_US * `FESB_CLK_MHZ)
`define FESB_SEC_TICKS `FESB_RX_CLK_HZ
`endif

// File: hdl/fesb_pkg.sv
// Types of the event status bank.
// Assumes the constants header sits beside it.
package fesb_pkg;
  typedef enum logic [1:0] {
    LLB_NONE = 2'b00,
    LLB_ACT = 2'b01,
    LLB_DEACT = 2'b10
  } fesb_llb_type;

  // Event pulses and levels from the framer and HDLC channel two
  typedef struct packed {
    logic [6:0] es_src;
    logic alarm_sim;
    logic rx_slip_neg;
    logic rx_slip_pos;
    logic tx_slip_pos;
    logic tx_slip_neg;
    logic rx_msg_end;
    logic rx_frame_start;
    logic rx_overflow;
    logic rx_pool_full;
    logic tx_all_sent;
    logic tx_underrun;
  } fesb_event_type;

  typedef struct packed {
    logic act_code;
    logic deact_code;
    logic ber_low;
    logic prbs_sync;
  } fesb_llb_in_type;
endpackage

// File: hdl/fesb_bank.sv
// Event status bank three and four with masks, summary and interrupt pin.
// Assumes all event inputs come from logic on clk; AHB-Lite slave, zero wait.
`timescale 1ns/100ps
`include "fesb_defs.svh"

// Behaviour
// - Reading status three or four clears it
// - Visible option records masked events too
// - Masked events stay off pin and summary
// - Errored second from enabled sources per second
// - Second flag on each one-second expiry
// - Loopback code held 33.16 ms flags change
// - Leaving detection on high errors flags change
// - Pattern mode flags every synchronizer change
// - Faster receive line clock sets negative slip
// - Slower receive line clock sets positive slip
// - Slower transmit clock sets positive slip
// - Faster transmit clock sets negative slip
// - Transmit slip recovers without control rewrite
// - Message end flag on frame end stored
// - Byte count register shows message length
// - Frame start flag two bytes after start
// - Overflow flagged, reception continues later
// - Overflow flag raised immediately on overflow
// - All-sent flag only in HDLC mode
// - Underrun aborts frame, sets underrun flag
// - Transmitter held until status four read
// - Pool full flag on 32 bytes arrived
// - Summary shows which registers have pending events
module fesb_bank #(
  parameter int SEC_TICKS = `FESB_SEC_TICKS,
  parameter int LLB_CYCLES = `FESB_LLB_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_clk_tick,
  input wire fesb_pkg::fesb_event_type events,
  input wire fesb_pkg::fesb_llb_in_type llb_in,
  input wire logic [11:0] rx_msg_length,
  output logic interrupt_n,
  output logic loopback_activate_detected,
  output logic loopback_deactivate_detected,
  output logic chan2_tx_hold
);
  logic [7:0] status3_r;
  logic [7:0] status4_r;
  logic [7:0] mask3_r;
  logic [7:0] mask4_r;
  logic [7:0] ctrl_r;
  logic [6:0] es_mask_r;
  logic [7:0] gsum;
  logic [7:0] ev3;
  logic [7:0] ev4;
  logic rd3;
  logic rd4;
  logic acc;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_nxt;
  logic [31:0] sec_cnt_r;
  logic sec_expire;
  logic es_seen_r;
  logic es_event;
  fesb_pkg::fesb_llb_type llb_state_r;
  logic [31:0] llb_cnt_r;
  logic llb_change;
  logic prbs_prev_r;
  logic tx_hold_r;

  // Mask gate: record when unmasked or visible option set
  function automatic logic [7:0] record_gate(input logic [7:0] ev, input logic [7:0] mask,
                                             input logic vis);
    record_gate = vis ? ev : (ev & ~mask);
  endfunction

  // AHB address phase
  assign acc = hsel && hready && htrans[1];
  assign rd3 = acc && !hwrite && (haddr[7:0] == `FESB_OFS_STATUS3);
  assign rd4 = acc && !hwrite && (haddr[7:0] == `FESB_OFS_STATUS4);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    if (haddr[7:0] == `FESB_OFS_STATUS3)
      rdata_nxt = {24'h000000, status3_r};
    else if (haddr[7:0] == `FESB_OFS_STATUS4)
      rdata_nxt = {24'h000000, status4_r};
    else if (haddr[7:0] == `FESB_OFS_MASK3)
      rdata_nxt = {24'h000000, mask3_r};
    else if (haddr[7:0] == `FESB_OFS_MASK4)
      rdata_nxt = {24'h000000, mask4_r};
    else if (haddr[7:0] == `FESB_OFS_CTRL)
      rdata_nxt = {24'h000000, ctrl_r};
    else if (haddr[7:0] == `FESB_OFS_ES_MASK)
      rdata_nxt = {25'h0000000, es_mask_r};
    else if (haddr[7:0] == `FESB_OFS_GSUM)
      rdata_nxt = {24'h000000, gsum};
    else if (haddr[7:0] == `FESB_OFS_RX_COUNT)
      rdata_nxt = {20'h00000, rx_msg_length};
    else
      rdata_nxt = 32'h00000000;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      hrdata <= 32'h00000000;
    else if (acc && !hwrite)
      hrdata <= rdata_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Writable registers, data phase
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      mask3_r <= `FESB_RST_MASK;
      mask4_r <= `FESB_RST_MASK;
      ctrl_r <= `FESB_RST_CTRL;
      es_mask_r <= 7'(`FESB_RST_ES_MASK);
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == `FESB_OFS_MASK3)
        mask3_r <= hwdata[7:0];
      else if (wr_addr_r == `FESB_OFS_MASK4)
        mask4_r <= hwdata[7:0];
      else if (wr_addr_r == `FESB_OFS_CTRL)
        ctrl_r <= {5'h00, hwdata[2:0]};
      else if (wr_addr_r == `FESB_OFS_ES_MASK)
        es_mask_r <= hwdata[6:0];
    end
  end

  // One-second timer on receive clock ticks
  assign sec_expire = rx_clk_tick && (sec_cnt_r == 32'(SEC_TICKS - 1));
  always_ff @(posedge clk)
  begin
    if (!resetn)
      sec_cnt_r <= 32'h00000000;
    else if (sec_expire)
      sec_cnt_r <= 32'h00000000;
    else if (rx_clk_tick)
      sec_cnt_r <= sec_cnt_r + 32'h00000001;
  end

  // Errored second accumulation
  assign es_event = sec_expire && (es_seen_r || |(events.es_src & es_mask_r));
  always_ff @(posedge clk)
  begin
    if (!resetn)
      es_seen_r <= 1'b0;
    else if (sec_expire)
      es_seen_r <= 1'b0;
    else if (|(events.es_src & es_mask_r))
      es_seen_r <= 1'b1;
  end

  // Loopback code detector
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      llb_state_r <= fesb_pkg::LLB_NONE;
      llb_cnt_r <= 32'h00000000;
    end
    else
    begin
      case (llb_state_r)
        fesb_pkg::LLB_NONE:
        begin
          if (llb_in.ber_low && (llb_in.act_code ^ llb_in.deact_code))
          begin
            if (llb_cnt_r == 32'(LLB_CYCLES - 1))
            begin
              llb_cnt_r <= 32'h00000000;
              llb_state_r <= llb_in.act_code ? fesb_pkg::LLB_ACT : fesb_pkg::LLB_DEACT;
            end
            else
              llb_cnt_r <= llb_cnt_r + 32'h00000001;
          end
          else
            llb_cnt_r <= 32'h00000000;
        end
        fesb_pkg::LLB_ACT, fesb_pkg::LLB_DEACT:
        begin
          llb_cnt_r <= 32'h00000000;
          if (!llb_in.ber_low)
            llb_state_r <= fesb_pkg::LLB_NONE;
        end
        default:
        begin
          llb_state_r <= fesb_pkg::LLB_NONE;
          llb_cnt_r <= 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      prbs_prev_r <= 1'b0;
    else
      prbs_prev_r <= llb_in.prbs_sync;
  end

  always_comb
  begin
    if (ctrl_r[`FESB_CTRL_EPRM])
      llb_change = llb_in.prbs_sync != prbs_prev_r;
    else if (llb_state_r == fesb_pkg::LLB_NONE)
      llb_change = llb_in.ber_low && (llb_in.act_code ^ llb_in.deact_code)
                   && (llb_cnt_r == 32'(LLB_CYCLES - 1));
    else
      llb_change = !llb_in.ber_low;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      loopback_activate_detected <= 1'b0;
      loopback_deactivate_detected <= 1'b0;
    end
    else
    begin
      loopback_activate_detected <= ctrl_r[`FESB_CTRL_EPRM] ? llb_in.prbs_sync
                                    : (llb_state_r == fesb_pkg::LLB_ACT);
      loopback_deactivate_detected <= !ctrl_r[`FESB_CTRL_EPRM]
                                      && (llb_state_r == fesb_pkg::LLB_DEACT);
    end
  end

  // Event vectors
  always_comb
  begin
    ev3 = 8'h00;
    ev3[`FESB_S3_ES] = es_event;
    ev3[`FESB_S3_SEC] = sec_expire;
    ev3[`FESB_S3_LOOPBACK_STATUS_CHANGE_FLAG] = llb_change;
    ev3[`FESB_S3_RSN] = events.rx_slip_neg || events.alarm_sim;
    ev3[`FESB_S3_RSP] = events.rx_slip_pos || events.alarm_sim;
    ev4 = 8'h00;
    ev4[`FESB_S4_XSP] = events.tx_slip_pos;
    ev4[`FESB_S4_XSN] = events.tx_slip_neg;
    ev4[`FESB_S4_RME] = events.rx_msg_end;
    ev4[`FESB_S4_RFS] = events.rx_frame_start;
    ev4[`FESB_S4_RDO] = events.rx_overflow;
    ev4[`FESB_S4_ALLS] = events.tx_all_sent && ctrl_r[`FESB_CTRL_HDLC];
    ev4[`FESB_S4_XDU] = events.tx_underrun;
    ev4[`FESB_S4_RPF] = events.rx_pool_full;
  end

  // Status registers, set wins over read clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
      status3_r <= 8'h00;
    else
      status3_r <= (rd3 ? 8'h00 : status3_r)
                   | record_gate(ev3, mask3_r, ctrl_r[`FESB_CTRL_VIS]);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      status4_r <= 8'h00;
    else
      status4_r <= (rd4 ? 8'h00 : status4_r)
                   | record_gate(ev4, mask4_r, ctrl_r[`FESB_CTRL_VIS]);
  end

  // Transmitter hold after underrun
  always_ff @(posedge clk)
  begin
    if (!resetn)
      tx_hold_r <= 1'b0;
    else if (ev4[`FESB_S4_XDU])
      tx_hold_r <= 1'b1;
    else if (rd4)
      tx_hold_r <= 1'b0;
  end
  assign chan2_tx_hold = tx_hold_r;

  // Summary and pin only see unmasked bits
  always_comb
  begin
    gsum = 8'h00;
    gsum[`FESB_GSUM_S3] = |(status3_r & ~mask3_r);
    gsum[`FESB_GSUM_S4] = |(status4_r & ~mask4_r);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      interrupt_n <= 1'b1;
    else
      interrupt_n <= !(|gsum);
  end

  a_read_clears3: assert property (@(posedge clk) disable iff (!resetn)
    rd3 && !(|record_gate(ev3, mask3_r, ctrl_r[`FESB_CTRL_VIS])) |=> status3_r == 8'h00)
    else $error("status three not cleared by read");

  a_read_clears4: assert property (@(posedge clk) disable iff (!resetn)
    rd4 && !(|record_gate(ev4, mask4_r, ctrl_r[`FESB_CTRL_VIS])) |=> status4_r == 8'h00)
    else $error("status four not cleared by read");

  a_vis_records: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_r[`FESB_CTRL_VIS] && events.rx_msg_end |=> status4_r[`FESB_S4_RME])
    else $error("visible masked event not recorded");

  a_masked_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ((status3_r & ~mask3_r) == 8'h00) && ((status4_r & ~mask4_r) == 8'h00)
    |=> interrupt_n)
    else $error("pin asserted by masked events");

  a_mask_blocks: assert property (@(posedge clk) disable iff (!resetn)
    !ctrl_r[`FESB_CTRL_VIS] && mask3_r[`FESB_S3_SEC] && rd3 |=> !status3_r[`FESB_S3_SEC])
    else $error("masked event recorded without visible option");

  a_second_flag: assert property (@(posedge clk) disable iff (!resetn)
    sec_expire && !mask3_r[`FESB_S3_SEC] |=> status3_r[`FESB_S3_SEC] ##1 !interrupt_n)
    else $error("second flag or pin missing after expiry");

  a_slip_flags: assert property (@(posedge clk) disable iff (!resetn)
    events.alarm_sim && !mask3_r[`FESB_S3_RSN] |=> status3_r[`FESB_S3_RSN]
    && $past(events.alarm_sim))
    else $error("alarm simulation did not set slip flag");

  a_alls_hdlc: assert property (@(posedge clk) disable iff (!resetn)
    !ctrl_r[`FESB_CTRL_HDLC] && rd4 |=> !status4_r[`FESB_S4_ALLS])
    else $error("all sent flagged outside HDLC mode");

  a_hold_until_read: assert property (@(posedge clk) disable iff (!resetn)
    events.tx_underrun ##1 !rd4 |=> chan2_tx_hold)
    else $error("transmitter released before status four read");

  a_summary_bits: assert property (@(posedge clk) disable iff (!resetn)
    ((status4_r & ~mask4_r) != 8'h00) |=> !interrupt_n)
    else $error("pending status four did not reach pin");

  a_summary_three: assert property (@(posedge clk) disable iff (!resetn)
    ((status3_r & ~mask3_r) != 8'h00) |=> !interrupt_n)
    else $error("pending status three did not reach pin");
endmodule

// File: bench/fesb_host.sv
// Host model: AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
module fesb_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// File: bench/tb_framer_event_status_bank.sv
// Testbench of the event status bank.
// Assumes fesb_pkg, fesb_bank and fesb_host compiled first.
`timescale 1ns/100ps
module tb_framer_event_status_bank;
  logic clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic rx_clk_tick;
  fesb_pkg::fesb_event_type events;
  fesb_pkg::fesb_llb_in_type llb_in;
  logic [11:0] rx_msg_length;
  logic interrupt_n;
  logic act_det;
  logic deact_det;
  logic tx_hold;
  logic [31:0] q;
  int mismatches;
  int samples_checked;

  fesb_bank #(.SEC_TICKS(10), .LLB_CYCLES(8)) i_dut (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_clk_tick(rx_clk_tick), .events(events), .llb_in(llb_in),
    .rx_msg_length(rx_msg_length), .interrupt_n(interrupt_n),
    .loopback_activate_detected(act_det), .loopback_deactivate_detected(deact_det),
    .chan2_tx_hold(tx_hold));

  fesb_host i_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic pulse(input logic [17:0] v);
    events <= v;
    @(posedge clk);
    events <= '0;
  endtask

  task automatic ev(input logic [17:0] v, input logic [7:0] a, input logic [31:0] e);
    pulse(v);
    rd(a, e);
  endtask

  task automatic tick(input logic [17:0] v);
    pulse(v);
    rx_clk_tick <= 1'b1;
    wt(12);
    rx_clk_tick <= 1'b0;
  endtask

  task automatic t_reset;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h10, 32'h4);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    chk("irq", 1'b1, interrupt_n);
    chk("hresp", 1'b0, hresp);
  endtask

  task automatic t_regs;
    wr(8'h0c, 32'hffff_ff5a);
    rd(8'h0c, 32'h5a);
    wr(8'h14, 32'hff);
    rd(8'h14, 32'h7f);
    wr(8'h18, 32'hff);
    rd(8'h18, 32'h0);
    wr(8'h0c, 32'h0);
    rx_msg_length <= 12'h9a5;
    rd(8'h1c, 32'h9a5);
  endtask

  task automatic t_clear;
    pulse(18'h20);
    rd(8'h18, 32'h10);
    chk("irq", 1'b0, interrupt_n);
    rd(8'h04, 32'h20);
    rd(8'h04, 32'h0);
    chk("irq", 1'b1, interrupt_n);
    pulse(18'h200);
    rd(8'h18, 32'h8);
    rd(8'h00, 32'h2);
    rd(8'h00, 32'h0);
  endtask

  task automatic t_mask;
    wr(8'h0c, 32'hff);
    ev(18'h10, 8'h04, 32'h0);
    wr(8'h10, 32'h5);
    pulse(18'h10);
    rd(8'h18, 32'h0);
    chk("irq", 1'b1, interrupt_n);
    rd(8'h04, 32'h10);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h4);
  endtask

  task automatic t_events;
    ev(18'h80, 8'h04, 32'h80);
    ev(18'h80, 8'h04, 32'h80);
    ev(18'h40, 8'h04, 32'h40);
    ev(18'h08, 8'h04, 32'h08);
    ev(18'h04, 8'h04, 32'h01);
    ev(18'h02, 8'h04, 32'h04);
    ev(18'h10, 8'h04, 32'h10);
    ev(18'h400, 8'h00, 32'h03);
    ev(18'h100, 8'h00, 32'h01);
    pulse(18'h01);
    wt(1);
    chk("hold", 1'b1, tx_hold);
    wt(3);
    chk("hold", 1'b1, tx_hold);
    rd(8'h04, 32'h02);
    chk("hold", 1'b0, tx_hold);
    wr(8'h10, 32'h0);
    ev(18'h02, 8'h04, 32'h0);
    wr(8'h10, 32'h4);
  endtask

  task automatic t_second;
    wr(8'h14, 32'h7f);
    tick(18'h800);
    rd(8'h00, 32'hc0);
    wr(8'h14, 32'h0);
    tick(18'h800);
    rd(8'h00, 32'h40);
  endtask

  task automatic t_loop;
    llb_in <= 4'b1010;
    wt(3);
    rd(8'h00, 32'h0);
    wt(8);
    rd(8'h00, 32'h08);
    chk("act", 1'b1, act_det);
    llb_in <= 4'b1000;
    wt(3);
    rd(8'h00, 32'h08);
    llb_in <= 4'b0110;
    wt(12);
    rd(8'h00, 32'h08);
    chk("deact", 1'b1, deact_det);
    llb_in <= 4'b0000;
    wr(8'h10, 32'h6);
    rd(8'h00, 32'h08);
    llb_in <= 4'b0001;
    wt(2);
    rd(8'h00, 32'h08);
    chk("act", 1'b1, act_det);
    llb_in <= 4'b0000;
    wt(2);
    rd(8'h00, 32'h08);
    chk("act", 1'b0, act_det);
    wr(8'h10, 32'h4);
  endtask

  initial
  begin
    resetn = 1'b0;
    rx_clk_tick = 1'b0;
    events = '0;
    llb_in = '0;
    rx_msg_length = 12'h0;
    mismatches = 0;
    samples_checked = 0;
    wt(5);
    resetn <= 1'b1;
    wt(1);
    t_reset();
    t_regs();
    t_clear();
    t_mask();
    t_events();
    t_second();
    t_loop();
    close_out();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    #100us;
    mismatches++;
    close_out();
  end
endmodule
